// ==== common/iuv_pkg.sv ====
// constants and types for the input undervoltage response and turn-on sequencer
package iuv_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_UV_RESP = 8'h5a;
  localparam logic [7:0] CMD_PG_ON = 8'h5e;
  localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] UV_RESP_RST = 8'h80;
  localparam logic [15:0] TURN_ON_DELAY_TIME_RST = 16'hca80;
  localparam logic [15:0] TURN_ON_RISE_TIME_RST = 16'hca80;
  localparam int BEHAV_MSB = 7;
  localparam int BEHAV_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam logic [1:0] BEHAV_DISABLE = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] RETRY_TIME_RB = 3'h7;
  localparam int STAT_OFF_BIT = 6;
  localparam int STAT_UV_BIT = 3;
  localparam int LIN11_EXP_MSB = 15;
  localparam int LIN11_EXP_LSB = 11;
  localparam int LIN11_MAN_MSB = 10;
  localparam logic [3:0] PG_NUM = 4'h9;
  localparam logic [3:0] PG_DEN = 4'ha;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int RETRY_MS = 70;
  localparam int DELAY_MIN_MS = 0;
  localparam int DELAY_MAX_MS = 5000;
  localparam int RISE_MIN_MS = 5;
  localparam int RISE_MAX_MS = 100;
  localparam int MS_W = 13;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } iuv_cmd_s;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DELAY = 3'h1,
    ST_RISE = 3'h2,
    ST_ON = 3'h3,
    ST_FAULT = 3'h4
  } iuv_st_e;

  typedef struct packed {
    logic en_m;
    logic en_s;
    logic uv_m;
    logic uv_s;
    iuv_st_e st;
    logic [15:0] tdiv;
    logic tick;
    logic [MS_W-1:0] ms;
    logic [7:0] uv_resp;
    logic [15:0] pg_thr;
    logic [15:0] ton_dly;
    logic [15:0] turn_on_rise_time;
    logic init;
    logic uv_flag;
    logic alert;
    logic alert_n;
    logic pg;
    logic out_en;
    logic ramp;
    logic ramp_gain;
    logic [MS_W-1:0] ramp_ms;
    logic [15:0] rd_data;
    logic rd_valid;
  } iuv_state_s;

endpackage

// ==== hw/iuv_lin11.sv ====
// linear-11 word to whole milliseconds, clamped to a range
`timescale 1ns/100ps
module iuv_lin11 #(
  parameter int MIN_MS = 0,
  parameter int MAX_MS = 5000
) (
  // encoded word
  input wire logic [15:0] word_i,
  // decoded time
  output logic [iuv_pkg::MS_W-1:0] ms_o
);
  import iuv_pkg::*;

  logic signed [4:0] expo;
  logic signed [10:0] mant;
  logic [31:0] val;

  always_comb begin
    expo = word_i[LIN11_EXP_MSB:LIN11_EXP_LSB];
    mant = word_i[LIN11_MAN_MSB:0];
    val = 32'h0;
    if (!mant[10]) begin
      if (!expo[4]) begin
        val = {21'h0, mant} << expo;
      end else begin
        val = {21'h0, mant} >> (-expo);
      end
    end
    if (val < 32'(MIN_MS)) begin
      val = 32'(MIN_MS);
    end else if (val > 32'(MAX_MS)) begin
      val = 32'(MAX_MS);
    end
    ms_o = val[MS_W-1:0];
  end

endmodule

// ==== hw/iuv_seq.sv ====
// input undervoltage response, power-good and turn-on sequencer
`timescale 1ns/100ps
// Behaviour
// - response code 10 disables output, applies retry
// - fault pulls alert low, sets fault bit
// - fault bits cleared only by clear-faults
// - retry 000: stay off until cleared
// - retry 111: restart until off or fault
// - retry interval 70 ms, bits 2:0 read 111
// - response register byte wide, default 80h
// - power-good on above threshold, off below limit
// - power-good threshold defaults to 0.9 setpoint
// - wait turn-on delay, 0-5 s, default 5 ms
// - rise time used only outside multi-phase mode
// - rise time 5-100 ms, default 5 ms
// - timing words are linear-11 milliseconds
// - register writes refused while write protection active, clear-faults still taken
// - status byte bit 3 reports input undervoltage
module iuv_seq #(
  parameter int TICK_CYCLES = iuv_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // management command port
  input wire iuv_pkg::iuv_cmd_s cmd_i,
  input wire logic wp_active_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // enable sources and fault inputs
  input wire logic ctrl_pin_i,
  input wire logic op_on_i,
  input wire logic vin_uv_i,
  input wire logic other_fault_i,
  // output monitoring and straps
  input wire logic [15:0] vout_i,
  input wire logic [15:0] output_undervoltage_limit,
  input wire logic [15:0] vout_strap_i,
  input wire logic multiphase_i,
  // alert line, open drain
  input wire logic alert_line_n_i,
  output logic alert_line_n_o,
  output logic alert_line_n_oe,
  // power stage control
  output logic out_en_o,
  output logic ramp_o,
  output logic ramp_by_gain_o,
  output logic [iuv_pkg::MS_W-1:0] ramp_ms_o,
  output logic power_good_o
);
  import iuv_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_q;

  // two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // ----------------------------------------------------------------
  // decoded timing words
  // ----------------------------------------------------------------
  iuv_state_s s_q;
  iuv_state_s s_d;
  logic [MS_W-1:0] dly_ms;
  logic [MS_W-1:0] rise_ms;

  iuv_lin11 #(.MIN_MS(DELAY_MIN_MS), .MAX_MS(DELAY_MAX_MS)) u_dly (
    .word_i(s_q.ton_dly),
    .ms_o(dly_ms)
  );

  iuv_lin11 #(.MIN_MS(RISE_MIN_MS), .MAX_MS(RISE_MAX_MS)) u_rise (
    .word_i(s_q.turn_on_rise_time),
    .ms_o(rise_ms)
  );

  // 0.9 times the strapped setpoint
  function automatic logic [15:0] pg_default(input logic [15:0] sp);
    logic [19:0] prod;
    prod = {4'h0, sp} * {16'h0, PG_NUM};
    return 16'(prod / {16'h0, PG_DEN});
  endfunction

  // ----------------------------------------------------------------
  // combined next state
  // ----------------------------------------------------------------
  logic enabled;
  logic active;
  logic uv_hit;
  logic wr;
  logic rd;
  logic clr;
  logic retry_done;

  assign enabled = s_q.en_s && op_on_i && !other_fault_i;
  assign active = (s_q.st == ST_DELAY) || (s_q.st == ST_RISE) || (s_q.st == ST_ON);
  assign uv_hit = active && s_q.uv_s;
  assign wr = cmd_i.valid && cmd_i.write && !wp_active_i;
  assign rd = cmd_i.valid && !cmd_i.write;
  assign clr = cmd_i.valid && cmd_i.write && (cmd_i.code == CMD_CLEAR_FAULTS);
  assign retry_done = s_q.tick && (s_q.ms >= MS_W'(RETRY_MS - 1));

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    // pin synchronisers
    s_d.en_m = ctrl_pin_i;
    s_d.en_s = s_q.en_m;
    s_d.uv_m = vin_uv_i;
    s_d.uv_s = s_q.uv_m;
    // millisecond enable
    s_d.tick = 1'b0;
    if (s_q.tdiv >= 16'(TICK_CYCLES - 1)) begin
      s_d.tdiv = 16'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tdiv = s_q.tdiv + 16'h1;
    end
    if (s_q.tick) begin
      s_d.ms = s_q.ms + MS_W'(1);
    end
    // threshold default caught after reset release
    if (!s_q.init) begin
      s_d.init = 1'b1;
      s_d.pg_thr = pg_default(vout_strap_i);
    end
    if (wr) begin
      unique case (cmd_i.code)
        CMD_UV_RESP: s_d.uv_resp = cmd_i.wdata[7:0];
        CMD_PG_ON: s_d.pg_thr = cmd_i.wdata;
        CMD_TURN_ON_DELAY_TIME: s_d.ton_dly = cmd_i.wdata;
        CMD_TURN_ON_RISE_TIME: s_d.turn_on_rise_time = cmd_i.wdata;
        default: ;
      endcase
    end
    // register read back, unmapped reads zero
    if (rd) begin
      s_d.rd_valid = 1'b1;
      unique case (cmd_i.code)
        CMD_UV_RESP: s_d.rd_data = {8'h0, s_q.uv_resp[7:3], RETRY_TIME_RB};
        CMD_PG_ON: s_d.rd_data = s_q.pg_thr;
        CMD_TURN_ON_DELAY_TIME: s_d.rd_data = s_q.ton_dly;
        CMD_TURN_ON_RISE_TIME: s_d.rd_data = s_q.turn_on_rise_time;
        CMD_STATUS_BYTE: begin
          s_d.rd_data = 16'h0;
          s_d.rd_data[STAT_UV_BIT] = s_q.uv_flag;
          s_d.rd_data[STAT_OFF_BIT] = !s_q.out_en;
        end
        default: s_d.rd_data = 16'h0;
      endcase
    end
    // sticky fault bit, set beats clear
    if (clr) begin
      s_d.uv_flag = 1'b0;
    end
    if (uv_hit) begin
      s_d.uv_flag = 1'b1;
    end
    s_d.alert = s_d.uv_flag;
    s_d.alert_n = !s_d.uv_flag;
    if (vout_i > s_q.pg_thr) begin
      s_d.pg = 1'b1;
    end else if (vout_i < output_undervoltage_limit) begin
      s_d.pg = 1'b0;
    end
    // sequencer
    unique case (s_q.st)
      ST_OFF: begin
        if (enabled && !s_q.uv_flag && !s_q.uv_s) begin
          s_d.st = ST_DELAY;
          s_d.ms = '0;
        end
      end
      // hold off for the turn-on delay
      ST_DELAY: begin
        if (s_q.ms >= dly_ms) begin
          s_d.st = ST_RISE;
          s_d.ms = '0;
          s_d.out_en = 1'b1;
          s_d.ramp = 1'b1;
          s_d.ramp_gain = multiphase_i;
          s_d.ramp_ms = rise_ms;
        end
      end
      // timed ramp only outside multi-phase use
      ST_RISE: begin
        if (s_q.ramp_gain ? s_q.pg : (s_q.ms >= s_q.ramp_ms)) begin
          s_d.st = ST_ON;
          s_d.ramp = 1'b0;
        end
      end
      ST_ON: ;
      ST_FAULT: begin
        if (s_q.uv_resp[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER) begin
          if (retry_done && !s_q.uv_s) begin
            s_d.st = ST_DELAY;
            s_d.ms = '0;
          end
        end else if (!s_q.uv_flag) begin
          s_d.st = ST_OFF;
        end
      end
      default: s_d.st = ST_OFF;
    endcase
    if (uv_hit) begin
      s_d.st = ST_FAULT;
      s_d.ms = '0;
      s_d.out_en = 1'b0;
      s_d.ramp = 1'b0;
    end
    // off command or other fault ends retries
    if (!enabled && (s_q.st != ST_OFF)) begin
      s_d.st = ST_OFF;
      s_d.out_en = 1'b0;
      s_d.ramp = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      s_q <= '0;
      s_q.st <= ST_OFF;
      s_q.uv_resp <= UV_RESP_RST;
      s_q.ton_dly <= TURN_ON_DELAY_TIME_RST;
      s_q.turn_on_rise_time <= TURN_ON_RISE_TIME_RST;
      s_q.alert_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rd_data_o = s_q.rd_data;
  assign rd_valid_o = s_q.rd_valid;
  assign alert_line_n_o = s_q.alert_n;
  assign alert_line_n_oe = s_q.alert;
  assign out_en_o = s_q.out_en;
  assign ramp_o = s_q.ramp;
  assign ramp_by_gain_o = s_q.ramp_gain;
  assign ramp_ms_o = s_q.ramp_ms;
  assign power_good_o = s_q.pg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q);

  sequence s_uv_event;
    active && s_q.uv_s;
  endsequence

  sequence s_shut;
    !s_q.out_en && (s_q.st == ST_FAULT || s_q.st == ST_OFF);
  endsequence

  a_uv_shutdown: assert property (s_uv_event |=> s_shut)
    else $error("undervoltage did not disable output");

  a_alert_low: assert property (s_uv_event |=> alert_line_n_oe && !alert_line_n_o && s_q.uv_flag)
    else $error("alert not driven low on fault");

  a_flag_sticky: assert property (s_q.uv_flag && !clr |=> s_q.uv_flag)
    else $error("fault bit cleared without command");

  a_no_retry: assert property ((s_q.st == ST_FAULT) && s_q.uv_flag
    && (s_q.uv_resp[RETRY_MSB:RETRY_LSB] == RETRY_NONE) |=> s_q.st != ST_DELAY)
    else $error("restart without clear in no-retry mode");

  a_retry_go: assert property ((s_q.st == ST_FAULT) && enabled && !s_q.uv_s && retry_done
    && (s_q.uv_resp[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER) |=> s_q.st == ST_DELAY)
    else $error("continuous retry did not restart");

  a_retry_gap: assert property ($rose(s_q.st == ST_DELAY) && $past(s_q.st) == ST_FAULT
    |-> $past(s_q.ms) >= MS_W'(RETRY_MS - 1))
    else $error("retry interval shorter than 70 ms");

  // read answers the value held when the read was taken, even if a write follows at once
  a_resp_read: assert property (rd && cmd_i.code == CMD_UV_RESP
    |=> rd_valid_o && rd_data_o == {8'h0, $past(s_q.uv_resp[7:3]), RETRY_TIME_RB})
    else $error("response register read back wrong");

  a_pg_hold: assert property (power_good_o && vout_i >= output_undervoltage_limit |=> power_good_o)
    else $error("power-good dropped above limit");

  a_dly_wait: assert property ($rose(s_q.st == ST_RISE) |-> $past(s_q.ms) >= $past(dly_ms))
    else $error("rise started before turn-on delay");

  a_wp_block: assert property (cmd_i.valid && cmd_i.write && wp_active_i
    |=> $stable(s_q.ton_dly) && $stable(s_q.turn_on_rise_time) && $stable(s_q.uv_resp))
    else $error("write accepted under protection");

  a_status_uv: assert property (rd && cmd_i.code == CMD_STATUS_BYTE
    |=> rd_data_o[STAT_UV_BIT] == $past(s_q.uv_flag))
    else $error("status bit 3 does not match fault");

endmodule

// ==== verification/iuv_host.sv ====
// host model that issues reads and writes on the management command port
`timescale 1ns/100ps
module iuv_host (
  // clock
  input wire logic mclk,
  // command port
  output iuv_pkg::iuv_cmd_s cmd_o,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i
);
  import iuv_pkg::*;

  initial cmd_o = '0;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // one write, held over the taking edge, then released
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    #1;
    cmd_o = '{valid: 1'b1, write: 1'b1, code: code, wdata: data};
    @(posedge mclk);
    #1;
    cmd_o = '0;
  endtask

  // one read; the answer is awaited for a bounded number of edges
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    int n;
    @(posedge mclk);
    #1;
    cmd_o = '{valid: 1'b1, write: 1'b0, code: code, wdata: 16'h0000};
    @(posedge mclk);
    #1;
    cmd_o = '0;
    n = 0;
    while (rd_valid_i !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    data = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
  endtask
endmodule

// ==== verification/tb_iuv_seq.sv ====
// self-checking bench for the undervoltage response and turn-on sequencer
`timescale 1ns/100ps
module tb_iuv_seq;
  import iuv_pkg::*;

  localparam int TCYC = 10;
  logic mclk, rst_n, wp, ctrl, op_on, vin_uv, oth, mphase;
  logic [15:0] vout, uvlim, strap, rdat;
  logic alert_o, alert_oe, rd_valid, out_en, ramp, ramp_gain, pg;
  logic [MS_W-1:0] ramp_ms;
  iuv_cmd_s cmd;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] codes [4] = '{CMD_UV_RESP, CMD_PG_ON, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_RISE_TIME};
  logic [15:0] defs [4] = '{16'h0087, 16'h0900, 16'hca80, 16'hca80};

  // ----------------------------------------------------------------
  // design, host model and clock
  // ----------------------------------------------------------------
  iuv_seq #(.TICK_CYCLES(TCYC)) uut (
    .mclk(mclk), .rst_n(rst_n), .cmd_i(cmd), .wp_active_i(wp),
    .rd_data_o(rdat), .rd_valid_o(rd_valid), .ctrl_pin_i(ctrl), .op_on_i(op_on),
    .vin_uv_i(vin_uv), .other_fault_i(oth), .vout_i(vout),
    .output_undervoltage_limit(uvlim), .vout_strap_i(strap), .multiphase_i(mphase),
    .alert_line_n_i(alert_oe ? 1'b0 : 1'b1), .alert_line_n_o(alert_o),
    .alert_line_n_oe(alert_oe), .out_en_o(out_en), .ramp_o(ramp),
    .ramp_by_gain_o(ramp_gain), .ramp_ms_o(ramp_ms), .power_good_o(pg)
  );

  iuv_host host (.mclk(mclk), .cmd_o(cmd), .rd_data_i(rdat), .rd_valid_i(rd_valid));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rchk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(code, d);
    chk(d, exp);
  endtask

  // waits for the stage enable to reach a level, bounded
  task automatic wait_en(input logic lvl, input int lim);
    int n;
    n = 0;
    while (out_en !== lvl && n < lim) begin
      cyc_n(1);
      n++;
    end
    chk({15'h0, out_en}, {15'h0, lvl});
  endtask

  task automatic pg_step(input logic [15:0] v, input logic exp);
    vout = v;
    cyc_n(4);
    chk({15'h0, pg}, {15'h0, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // defaults, protection, unmapped read
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rchk(codes[i], defs[i]);
    end
    rchk(CMD_STATUS_BYTE, 16'h0040);
    rchk(8'h55, 16'h0000);
    wp = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.wr(codes[i], 16'h5555);
      rchk(codes[i], defs[i]);
    end
    wp = 1'b0;
    $display("test regs done");
  endtask

  // short delay, rise time with a negative exponent
  task automatic t_turn_on();
    host.wr(CMD_TURN_ON_DELAY_TIME, 16'h0003);
    rchk(CMD_TURN_ON_DELAY_TIME, 16'h0003);
    // rise kept at 10 ms, well clear of the short end
    host.wr(CMD_TURN_ON_RISE_TIME, 16'hf814);
    ctrl = 1'b1;
    op_on = 1'b1;
    cyc_n(15);
    chk({15'h0, out_en}, 16'h0000);
    wait_en(1'b1, 40);
    chk({14'h0, ramp, ramp_gain}, 16'h0002);
    chk({3'h0, ramp_ms}, 16'h000a);
    cyc_n(80);
    chk({15'h0, ramp}, 16'h0001);
    cyc_n(50);
    chk({15'h0, ramp}, 16'h0000);
    $display("test turn_on done");
  endtask

  // hysteresis between threshold and limit
  task automatic t_pgood();
    pg_step(16'h0800, 1'b0);
    pg_step(16'h0a00, 1'b1);
    pg_step(16'h0800, 1'b1);
    pg_step(16'h0600, 1'b0);
    $display("test pgood done");
  endtask

  // fault with no retry, held off until cleared
  task automatic t_uv_hold();
    vin_uv = 1'b1;
    cyc_n(4);
    chk({13'h0, out_en, alert_o, alert_oe}, 16'h0001);
    vin_uv = 1'b0;
    cyc_n(900);
    chk({15'h0, out_en}, 16'h0000);
    rchk(CMD_STATUS_BYTE, 16'h0048);
    host.wr(CMD_CLEAR_FAULTS, 16'h0000);
    cyc_n(2);
    chk({14'h0, alert_o, alert_oe}, 16'h0002);
    rchk(CMD_STATUS_BYTE, 16'h0040);
    wait_en(1'b1, 60);
    $display("test uv_hold done");
  endtask

  // endless retry at the fixed interval, stopped by another fault
  task automatic t_uv_retry();
    host.wr(CMD_UV_RESP, 16'h00b8);
    rchk(CMD_UV_RESP, 16'h00bf);
    cyc_n(150);
    vin_uv = 1'b1;
    cyc_n(4);
    vin_uv = 1'b0;
    chk({15'h0, out_en}, 16'h0000);
    cyc_n(550);
    chk({15'h0, out_en}, 16'h0000);
    wait_en(1'b1, 300);
    rchk(CMD_STATUS_BYTE, 16'h0008);
    oth = 1'b1;
    cyc_n(4);
    chk({15'h0, out_en}, 16'h0000);
    cyc_n(900);
    chk({15'h0, out_en}, 16'h0000);
    $display("test uv_retry done");
  endtask

  // multi-phase start: ramp ends on power-good, the rise time is ignored
  task automatic t_mphase();
    oth = 1'b0;
    mphase = 1'b1;
    vout = 16'h0000;
    host.wr(CMD_CLEAR_FAULTS, 16'h0000);
    wait_en(1'b1, 60);
    chk({14'h0, ramp, ramp_gain}, 16'h0003);
    // well past the 10 ms rise time, still ramping without power-good
    cyc_n(150);
    chk({15'h0, ramp}, 16'h0001);
    vout = 16'h0a00;
    cyc_n(3);
    chk({14'h0, ramp, pg}, 16'h0001);
    $display("test mphase done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    ctrl = 1'b0;
    op_on = 1'b0;
    vin_uv = 1'b0;
    oth = 1'b0;
    mphase = 1'b0;
    vout = 16'h0000;
    uvlim = 16'h0700;
    strap = 16'h0a00;
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    cyc_n(4);
    t_regs();
    t_turn_on();
    t_pgood();
    t_uv_hold();
    t_uv_retry();
    t_mphase();
    complete_run();
  end
endmodule
